// ==== hdl/krc_pkg.sv ====
// shared constants for the keyboard report codec
package krc_pkg;
	localparam logic [7:0] HDR_MEDIA       = 8'hFF;
	localparam logic [7:0] HDR_POWER       = 8'hFE;
	localparam logic [7:0] HDR_BATTERY     = 8'hFD;
	localparam logic [7:0] HDR_KEEPALIVE   = 8'hFC;
	localparam logic [7:0] HDR_LIMIT       = 8'hFC;
	localparam logic [7:0] PKT_HEADER      = 8'h40;
	localparam logic [7:0] BATT_MIN        = 8'h01;
	localparam logic [7:0] BATT_MAX        = 8'h0A;
	localparam int         REPORT_LEN      = 7;
	localparam int         PAYLOAD_POS     = 2;
	localparam int         CLK_HZ          = 10000000;
	localparam int         IDLE_SECONDS    = 8;
	localparam int         IDLE_CYCLES     = IDLE_SECONDS * CLK_HZ;
	localparam int         KEEPALIVE_MS    = 100;
	localparam int         KEEPALIVE_CYC   = KEEPALIVE_MS * (CLK_HZ / 1000);
	localparam int         RELEASE_MS      = 300;
	localparam int         RELEASE_CYC     = RELEASE_MS * (CLK_HZ / 1000);
	localparam int         ROWS            = 8;
	localparam int         COLS            = 16;
	typedef enum logic [2:0] {
		KS_IDLE  = 3'b000,
		KS_HDR   = 3'b001,
		KS_BYTES = 3'b011,
		KS_BATT  = 3'b010,
		KS_BATV  = 3'b110
	} krc_tx_state_type;
endpackage

// ==== hdl/krc_link_if.sv ====
// byte stream link between keyboard and bridge
interface krc_link_if;
	logic       valid;
	logic       ready;
	logic [7:0] data;
	logic       last;
	modport kbd (output valid, output data, output last, input ready);
	modport brg (input valid, input data, input last, output ready);
endinterface

// ==== hdl/krc_keyboard.sv ====
// keyboard end: report framing, ghost suppression, battery and keep-alive
module krc_keyboard
	import krc_pkg::*;
#(
	parameter int IDLE_LIMIT = IDLE_CYCLES,
	parameter int KA_LIMIT   = KEEPALIVE_CYC
)(
	input  wire logic             clk,
	input  wire logic             rstn,
	input  wire logic [ROWS*COLS-1:0] key_matrix,
	input  wire logic             row_event,
	input  wire logic             bind_event,
	input  wire logic             rpt_valid,
	input  wire logic [7:0]       rpt_kind,
	input  wire logic [7:0]       rpt_code1,
	input  wire logic [7:0]       rpt_mod,
	input  wire logic [7:0]       rpt_code2,
	input  wire logic [7:0]       rpt_code3,
	input  wire logic [7:0]       rpt_code4,
	input  wire logic [7:0]       rpt_code5,
	input  wire logic [7:0]       rpt_code6,
	input  wire logic [7:0]       battery_level,
	input  wire logic             key_held,
	output logic                  rpt_ready,
	output logic                  ghost,
	output logic                  row_pending,
	output logic                  bind_pending,
	input  wire logic             row_consume,
	input  wire logic             bind_consume,
	krc_link_if.kbd               link
);
	krc_tx_state_type st_q;
	logic [7:0]  buf_q [REPORT_LEN];
	logic [2:0]  len_q;
	logic [2:0]  idx_q;
	logic [31:0] idle_q;
	logic        stale_q;
	logic        batt_due_q;
	logic [7:0]  batt_q;
	logic [31:0] ka_q;
	logic        ka_due_q;
	logic        ghost_q;
	logic        row_q;
	logic        bind_q;
	logic        data_last_q;
	logic [7:0]  data_q;
	logic        valid_q;
	logic [7:0]  raw [REPORT_LEN];
	logic [2:0]  raw_len;
	logic        power_kind;
	logic [7:0]  lvl;
	logic        keystroke;

	// ghost detection: two keys in a row and two in a column sharing one key
	always_comb
	begin
		logic hit;
		hit = 1'b0;
		for (int r = 0; r < ROWS; r++)
			for (int c = 0; c < COLS; c++)
				if (key_matrix[r*COLS+c])
					for (int r2 = 0; r2 < ROWS; r2++)
						for (int c2 = 0; c2 < COLS; c2++)
							if (r2 != r && c2 != c && key_matrix[r*COLS+c2]
								&& key_matrix[r2*COLS+c])
								hit = 1'b1;
		ghost = hit;
	end

	always_ff @(posedge clk or negedge rstn)
		if (!rstn)
			ghost_q <= 1'b0;
		else
			ghost_q <= ghost;

	// pending flags; a new event wins over consume
	always_ff @(posedge clk or negedge rstn)
		if (!rstn)
		begin
			row_q  <= 1'b0;
			bind_q <= 1'b0;
		end
		else
		begin
			row_q  <= row_event | (row_q & ~row_consume);
			bind_q <= bind_event | (bind_q & ~bind_consume);
		end
	assign row_pending  = row_q;
	assign bind_pending = bind_q;

	assign keystroke = rpt_valid & rpt_ready;

	// idle timer for battery reporting
	always_ff @(posedge clk or negedge rstn)
		if (!rstn)
		begin
			idle_q  <= 32'h0;
			stale_q <= 1'b0;
		end
		else if (keystroke || row_event)
		begin
			idle_q  <= 32'h0;
			stale_q <= 1'b0;
		end
		else if (idle_q >= 32'(IDLE_LIMIT))
			stale_q <= 1'b1;
		else
			idle_q <= idle_q + 32'h1;

	// keep-alive period while a key is held
	always_ff @(posedge clk or negedge rstn)
		if (!rstn)
		begin
			ka_q     <= 32'h0;
			ka_due_q <= 1'b0;
		end
		else if (!key_held || keystroke)
		begin
			ka_q     <= 32'h0;
			ka_due_q <= 1'b0;
		end
		else if (st_q == KS_IDLE && ka_due_q && !ghost_q)
			ka_due_q <= 1'b0;
		else if (ka_q >= 32'(KA_LIMIT - 1))
		begin
			ka_q     <= 32'h0;
			ka_due_q <= 1'b1;
		end
		else
			ka_q <= ka_q + 32'h1;

	// clamp battery level into its coded range
	assign lvl = (battery_level < BATT_MIN) ? BATT_MIN :
		(battery_level > BATT_MAX) ? BATT_MAX : battery_level;

	// assemble full report, then strip trailing zeros
	assign power_kind = (rpt_kind == HDR_POWER);
	always_comb
	begin
		for (int i = 0; i < REPORT_LEN; i++)
			raw[i] = 8'h00;
		if (power_kind)
		begin
			raw[0] = HDR_POWER;
			raw[1] = rpt_code1;
		end
		else if (rpt_kind == HDR_MEDIA)
		begin
			raw[0] = HDR_MEDIA;
			raw[1] = rpt_code1;
			raw[2] = rpt_code2;
		end
		else
		begin
			raw[0] = (rpt_code1 < HDR_LIMIT) ? rpt_code1 : 8'h00;
			raw[1] = rpt_mod;
			raw[2] = rpt_code2;
			raw[3] = rpt_code3;
			raw[4] = rpt_code4;
			raw[5] = rpt_code5;
			raw[6] = rpt_code6;
		end
		raw_len = 3'd1;
		for (int i = 1; i < REPORT_LEN; i++)
			if (raw[i] != 8'h00)
				raw_len = 3'(i + 1);
	end

	assign rpt_ready = (st_q == KS_IDLE) && !ghost_q && !ka_due_q;

	// transmit sequencer: packet header byte then payload from position one
	always_ff @(posedge clk or negedge rstn)
		if (!rstn)
		begin
			st_q        <= KS_IDLE;
			len_q       <= 3'd0;
			idx_q       <= 3'd0;
			batt_due_q  <= 1'b0;
			batt_q      <= 8'h00;
			valid_q     <= 1'b0;
			data_q      <= 8'h00;
			data_last_q <= 1'b0;
			for (int i = 0; i < REPORT_LEN; i++)
				buf_q[i] <= 8'h00;
		end
		else
			unique case (st_q)
				KS_IDLE:
					if (keystroke)
					begin
						for (int i = 0; i < REPORT_LEN; i++)
							buf_q[i] <= raw[i];
						len_q       <= raw_len;
						batt_due_q  <= stale_q;
						batt_q      <= lvl;
						valid_q     <= 1'b1;
						data_q      <= PKT_HEADER;
						data_last_q <= 1'b0;
						idx_q       <= 3'd0;
						st_q        <= KS_HDR;
					end
					else if (ka_due_q && !ghost_q)
					begin
						buf_q[0]    <= HDR_KEEPALIVE;
						len_q       <= 3'd1;
						batt_due_q  <= 1'b0;
						valid_q     <= 1'b1;
						data_q      <= PKT_HEADER;
						data_last_q <= 1'b0;
						idx_q       <= 3'd0;
						st_q        <= KS_HDR;
					end
				KS_HDR:
					if (link.ready)
					begin
						data_q      <= buf_q[0];
						data_last_q <= (len_q == 3'd1);
						idx_q       <= 3'd1;
						st_q        <= KS_BYTES;
					end
				KS_BYTES:
					if (link.ready)
					begin
						if (data_last_q)
						begin
							if (batt_due_q)
							begin
								data_q      <= PKT_HEADER;
								data_last_q <= 1'b0;
								st_q        <= KS_BATT;
							end
							else
							begin
								valid_q <= 1'b0;
								st_q    <= KS_IDLE;
							end
						end
						else
						begin
							data_q      <= buf_q[idx_q];
							data_last_q <= (3'(idx_q + 3'd1) == len_q);
							idx_q       <= 3'(idx_q + 3'd1);
						end
					end
				KS_BATT:
					if (link.ready)
					begin
						data_q <= HDR_BATTERY;
						st_q   <= KS_BATV;
					end
				KS_BATV:
					if (link.ready)
					begin
						if (data_q == HDR_BATTERY)
						begin
							data_q      <= batt_q;
							data_last_q <= 1'b1;
						end
						else
						begin
							batt_due_q <= 1'b0;
							valid_q    <= 1'b0;
							st_q       <= KS_IDLE;
						end
					end
				default:
					st_q <= KS_IDLE;
			endcase

	assign link.valid = valid_q;
	assign link.data  = data_q;
	assign link.last  = data_last_q;
endmodule

// ==== hdl/krc_bridge.sv ====
// bridge end: report decode, zero restore and release timeout
module krc_bridge
	import krc_pkg::*;
#(
	parameter int RELEASE_LIMIT = RELEASE_CYC
)(
	input  wire logic        clk,
	input  wire logic        rstn,
	krc_link_if.brg          link,
	output logic             out_valid,
	output logic [7:0]       out_kind,
	output logic [7:0]       out_b0,
	output logic [7:0]       out_b1,
	output logic [7:0]       out_b2,
	output logic [7:0]       out_b3,
	output logic [7:0]       out_b4,
	output logic [7:0]       out_b5,
	output logic [7:0]       out_b6,
	output logic             key_down,
	output logic             auto_release
);
	logic [7:0]  rx_q [REPORT_LEN];
	logic [2:0]  pos_q;
	logic        in_pkt_q;
	logic        ov_q;
	logic [7:0]  kind_q;
	logic        down_q;
	logic        rel_q;
	logic [31:0] tmo_q;
	logic [7:0]  ob_q [REPORT_LEN];
	logic        done;
	logic [7:0]  first;

	assign link.ready = 1'b1;
	assign done  = link.valid && link.last && in_pkt_q;
	assign first = (pos_q == 3'd0) ? link.data : rx_q[0];

	// collect payload; missing trailing bytes stay zero
	always_ff @(posedge clk or negedge rstn)
		if (!rstn)
		begin
			pos_q    <= 3'd0;
			in_pkt_q <= 1'b0;
			for (int i = 0; i < REPORT_LEN; i++)
				rx_q[i] <= 8'h00;
		end
		else if (link.valid)
		begin
			if (!in_pkt_q)
			begin
				in_pkt_q <= 1'b1;
				pos_q    <= 3'd0;
				for (int i = 0; i < REPORT_LEN; i++)
					rx_q[i] <= 8'h00;
			end
			else
			begin
				if (pos_q < 3'(REPORT_LEN))
					rx_q[pos_q] <= link.data;
				pos_q <= 3'(pos_q + 3'd1);
				if (link.last)
					in_pkt_q <= 1'b0;
			end
		end

	// decode finished report
	always_ff @(posedge clk or negedge rstn)
		if (!rstn)
		begin
			ov_q   <= 1'b0;
			kind_q <= 8'h00;
			for (int i = 0; i < REPORT_LEN; i++)
				ob_q[i] <= 8'h00;
		end
		else
		begin
			ov_q <= 1'b0;
			if (done && first != HDR_KEEPALIVE)
			begin
				ov_q   <= 1'b1;
				kind_q <= (first < HDR_LIMIT) ? 8'h00 : first;
				for (int i = 0; i < REPORT_LEN; i++)
					ob_q[i] <= (3'(i) == pos_q) ? link.data :
						(3'(i) < pos_q) ? rx_q[i] : 8'h00;
			end
			else if (rel_q)
			begin
				ov_q   <= 1'b1;
				kind_q <= 8'h00;
				for (int i = 0; i < REPORT_LEN; i++)
					ob_q[i] <= 8'h00;
			end
		end

	// key-down tracking and release timeout
	always_ff @(posedge clk or negedge rstn)
		if (!rstn)
		begin
			down_q <= 1'b0;
			tmo_q  <= 32'h0;
			rel_q  <= 1'b0;
		end
		else
		begin
			rel_q <= 1'b0;
			if (done)
			begin
				tmo_q <= 32'h0;
				if (first < HDR_LIMIT)
					down_q <= (first != 8'h00) || (pos_q != 3'd0);
				else if (first == HDR_POWER || first == HDR_MEDIA)
					down_q <= (pos_q != 3'd0);
			end
			else if (down_q)
			begin
				if (tmo_q >= 32'(RELEASE_LIMIT - 1))
				begin
					down_q <= 1'b0;
					rel_q  <= 1'b1;
					tmo_q  <= 32'h0;
				end
				else
					tmo_q <= tmo_q + 32'h1;
			end
		end

	assign out_valid    = ov_q;
	assign out_kind     = kind_q;
	assign out_b0       = ob_q[0];
	assign out_b1       = ob_q[1];
	assign out_b2       = ob_q[2];
	assign out_b3       = ob_q[3];
	assign out_b4       = ob_q[4];
	assign out_b5       = ob_q[5];
	assign out_b6       = ob_q[6];
	assign key_down     = down_q;
	assign auto_release = rel_q;
endmodule

// ==== bench/krc_link_chk.sv ====
// wire checks on the keyboard to bridge link
module krc_link_chk
	import krc_pkg::*;
(
	input wire logic       clk,
	input wire logic       rstn,
	input wire logic       valid,
	input wire logic       ready,
	input wire logic [7:0] data,
	input wire logic       last
);
	logic [3:0] pos_q;
	logic [7:0] b1_q;
	always_ff @(posedge clk or negedge rstn)
		if (!rstn)
			pos_q <= 4'h0;
		else if (valid && ready)
			pos_q <= last ? 4'h0 : pos_q + 4'h1;
	always_ff @(posedge clk or negedge rstn)
		if (!rstn)
			b1_q <= 8'h00;
		else if (valid && ready && pos_q == 4'h1)
			b1_q <= data;
	default clocking @(posedge clk); endclocking
	default disable iff (!rstn);
	sequence s_hdr;
		valid && pos_q == 4'h0 && data == PKT_HEADER;
	endsequence
	sequence s_pay;
		valid && pos_q == 4'h1;
	endsequence
	a_hdr_first: assert property (valid && pos_q == 4'h0 |-> data == PKT_HEADER && !last)
		else $error("bad packet header");
	a_pay_follow: assert property (s_hdr |=> s_pay)
		else $error("no payload after header");
	a_no_break: assert property (valid && !last |=> valid)
		else $error("packet broken");
	a_keep_alone: assert property ((s_pay and (data == HDR_KEEPALIVE)) |-> last)
		else $error("keep-alive too long");
	a_batt_pair: assert property ((s_pay and (data == HDR_BATTERY)) |-> !last
		##1 (valid && last && data >= BATT_MIN && data <= BATT_MAX))
		else $error("bad battery report");
	a_power_len: assert property (valid && pos_q == 4'h2 && b1_q == HDR_POWER |-> last)
		else $error("power report too long");
	a_strip_zero: assert property (valid && last && pos_q > 4'h1 |-> data != 8'h00)
		else $error("trailing zero sent");
	a_report_len: assert property (valid |-> pos_q <= 4'h7)
		else $error("report too long");
endmodule

// ==== bench/keyboard_report_codec_test.sv ====
// bench joining keyboard and bridge ends
module keyboard_report_codec_test
	import krc_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int IDLE_N = 50;
	localparam int KA_N = 20;
	logic                 clk, rstn, row_event, bind_event, rpt_valid, key_held;
	logic                 row_consume, bind_consume, rpt_ready, ghost;
	logic                 row_pending, bind_pending, out_valid, key_down, auto_release;
	logic [ROWS*COLS-1:0] key_matrix;
	logic [7:0]           rpt_kind, rpt_mod, battery_level, out_kind;
	logic [7:0]           code [1:6];
	logic [7:0]           ob [0:6];
	logic [63:0]          exp_q [$];
	logic [55:0]          b;
	logic [2:0]           tab [4] = '{3'h5, 3'h2, 3'h7, 3'h2};
	logic [7:0]           lvl [4] = '{8'h01, 8'h0A, 8'h07, 8'h0F};
	int                   failures, tests_run, n;
	bit                   seen;
	krc_link_if link_i ();
	krc_keyboard #(.IDLE_LIMIT(IDLE_N), .KA_LIMIT(KA_N)) krc_keyboard_inst (.clk(clk),
		.rstn(rstn), .key_matrix(key_matrix), .row_event(row_event), .bind_event(bind_event),
		.rpt_valid(rpt_valid), .rpt_kind(rpt_kind), .rpt_code1(code[1]), .rpt_mod(rpt_mod),
		.rpt_code2(code[2]), .rpt_code3(code[3]), .rpt_code4(code[4]), .rpt_code5(code[5]),
		.rpt_code6(code[6]), .battery_level(battery_level), .key_held(key_held),
		.rpt_ready(rpt_ready), .ghost(ghost), .row_pending(row_pending),
		.bind_pending(bind_pending), .row_consume(row_consume),
		.bind_consume(bind_consume), .link(link_i));
	krc_bridge #(.RELEASE_LIMIT(40)) krc_bridge_inst (.clk(clk), .rstn(rstn), .link(link_i),
		.out_valid(out_valid), .out_kind(out_kind), .out_b0(ob[0]), .out_b1(ob[1]),
		.out_b2(ob[2]), .out_b3(ob[3]), .out_b4(ob[4]), .out_b5(ob[5]), .out_b6(ob[6]),
		.key_down(key_down), .auto_release(auto_release));
	krc_link_chk krc_link_chk_inst (.clk(clk), .rstn(rstn), .valid(link_i.valid),
		.ready(link_i.ready), .data(link_i.data), .last(link_i.last));
	always #50 clk = ~clk;
	task chk_rep(input string s, input logic [63:0] e, input logic [63:0] g);
		tests_run++;
		if (g !== e)
		begin
			failures++;
			$display("CHECK FAILED %s expected %h seen %h", s, e, g);
		end
	endtask
	task chk_flag(input string s, input logic e, input logic g);
		chk_rep(s, {63'h0, e}, {63'h0, g});
	endtask
	task final_report;
		$display("checks %0d failures %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	// queue the expected result, then offer the report
	task send(input logic [7:0] k, input logic [55:0] v, input logic [7:0] lv);
		if (k == HDR_POWER)
			exp_q.push_back({k, k, v[55:48], 40'h0});
		else if (k == HDR_MEDIA)
			exp_q.push_back({k, k, v[55:48], v[39:32], 32'h0});
		else
			exp_q.push_back({8'h00, v});
		if (lv != 8'h00)
			exp_q.push_back({HDR_BATTERY, HDR_BATTERY, lv > BATT_MAX ? BATT_MAX : lv, 40'h0});
		@(posedge clk);
		rpt_valid <= 1'b1;
		rpt_kind <= k;
		{code[1], rpt_mod, code[2], code[3], code[4], code[5], code[6]} <= v;
		@(negedge clk);
		for (int i = 0; i < 300 && rpt_ready !== 1'b1; i++)
			@(negedge clk);
		@(posedge clk);
		rpt_valid <= 1'b0;
	endtask
	task drain;
		for (int i = 0; i < 200 && exp_q.size() > 0; i++)
			@(negedge clk);
		chk_flag("drained", 1'b1, exp_q.size() == 0);
	endtask
	// quiet window, then key_held drops and the bridge must release on its own
	task expect_release(input int quiet);
		seen = 1'b0;
		repeat (quiet)
		begin
			@(negedge clk);
			seen |= auto_release === 1'b1;
		end
		chk_flag("early_release", 1'b0, seen);
		exp_q.push_back(64'h0);
		@(posedge clk);
		key_held <= 1'b0;
		for (n = 0; n < 60 && auto_release !== 1'b1; n++)
			@(negedge clk);
		chk_flag("auto_release", 1'b1, auto_release);
		repeat (3) @(negedge clk);
		chk_flag("key_up", 1'b0, key_down);
	endtask
	task pulse(input logic e, input logic c, input int i);
		@(posedge clk);
		{bind_event, row_event} <= i ? {e, 1'b0} : {1'b0, e};
		{bind_consume, row_consume} <= i ? {c, 1'b0} : {1'b0, c};
		@(posedge clk);
		{bind_event, row_event, bind_consume, row_consume} <= 4'h0;
		@(negedge clk);
	endtask
	always @(negedge clk)
		if (out_valid === 1'b1)
		begin
			if (exp_q.size() > 0)
				chk_rep("report", exp_q.pop_front(), {out_kind, ob[0], ob[1], ob[2], ob[3],
					ob[4], ob[5], ob[6]});
			else
				chk_flag("unexpected", 1'b0, 1'b1);
		end
	initial
	begin
		repeat (20000) @(posedge clk);
		failures++;
		final_report;
	end
	initial
	begin
		clk = 1'b0;
		rstn = 1'b0;
		{row_event, bind_event, rpt_valid, row_consume, bind_consume, key_held} = 6'h00;
		{key_matrix, rpt_kind, rpt_mod, battery_level} = '0;
		code = '{default: 8'h00};
		void'($urandom(40442));
		repeat (16) @(posedge clk);
		rstn <= 1'b1;
		for (int i = 0; i < 6; i++)
		begin
			for (int j = 1; j < 7; j++)
				b[55 - 8 * j -: 8] = ($urandom % 2) ? 8'($urandom_range(1, 251)) : 8'h00;
			b[55:48] = 8'($urandom_range(1, 251));
			send(8'h00, i < 5 ? b : 56'h0, 8'h00);
		end
		send(HDR_MEDIA, {16'h0, 8'hE9, 32'h0}, 8'h00);
		send(HDR_POWER, {8'h02, 48'h0}, 8'h00);
		send(HDR_POWER, 56'h0, 8'h00);
		drain();
		send(8'h00, {8'h04, 48'h0}, 8'h00);
		drain();
		chk_flag("key_down", 1'b1, key_down);
		repeat (20) @(negedge clk);
		send(8'h00, {8'h04, 48'h0}, 8'h00);
		drain();
		expect_release(25);
		send(8'h00, {8'h04, 48'h0}, 8'h00);
		drain();
		@(posedge clk);
		key_held <= 1'b1;
		expect_release(150);
		foreach (lvl[i])
		begin
			repeat (IDLE_N + 10) @(posedge clk);
			battery_level <= lvl[i];
			send(8'h00, 56'h0, lvl[i]);
			drain();
		end
		@(posedge clk);
		key_matrix <= 128'h10003;
		repeat (3) @(negedge clk);
		chk_flag("ghost", 1'b1, ghost);
		fork
			send(8'h00, 56'h0, 8'h00);
			begin
				repeat (8) @(negedge clk);
				chk_flag("withheld", 1'b1, rpt_ready === 1'b0 && exp_q.size() == 1);
				@(posedge clk);
				key_matrix <= 128'h3;
			end
		join
		drain();
		chk_flag("ghost", 1'b0, ghost);
		for (int i = 0; i < 2; i++)
			foreach (tab[k])
			begin
				pulse(tab[k][2], tab[k][1], i);
				chk_flag("pending", tab[k][0], i ? bind_pending : row_pending);
			end
		final_report;
	end
endmodule
